// ### hdl/vap_params.svh
// Offsets, field positions, reset values and counts of the attribute stage.
`ifndef VAP_PARAMS_SVH
`define VAP_PARAMS_SVH

// Host I/O ports.
`define VAP_PORT_ATTR 10'h3C0
`define VAP_PORT_ATTR_DATA 10'h3C1
`define VAP_PORT_MASK 10'h3C6
`define VAP_PORT_PAL_RIDX 10'h3C7
`define VAP_PORT_PAL_WIDX 10'h3C8
`define VAP_PORT_STAT_MONO 10'h3BA
`define VAP_PORT_STAT_COLR 10'h3DA

// Attribute register indices.
`define VAP_IDX_COLOUR_TOP 5'h10
`define VAP_IDX_MODE 5'h10
`define VAP_IDX_BORDER 5'h11
`define VAP_IDX_PLANE 5'h12
`define VAP_IDX_PAN 5'h13
`define VAP_IDX_PAD 5'h14

// Field positions.
`define VAP_IDX_VIDEO_BIT 5
`define VAP_MODE_GFX 0
`define VAP_MODE_MONO 1
`define VAP_MODE_LGFX 2
`define VAP_MODE_BLINK 3
`define VAP_MODE_PANSPLIT 5
`define VAP_MODE_ASM256 6
`define VAP_MODE_PADSEL 7
`define VAP_MODE_WMASK 8'hEF

// Character codes that extend into the ninth dot.
`define VAP_LG_CODE_LO 8'hC0
`define VAP_LG_CODE_HI 8'hDF

// Panning value that means no shift in nine-dot text.
`define VAP_PAN_NINE_ZERO 4'h8

// Palette port state codes.
`define VAP_STATE_WMODE 2'h0
`define VAP_STATE_RMODE 2'h3

// Reset values and counts.
`define VAP_MASK_RST 8'hFF
`define VAP_BLINK_VSYNCS 8'h10

`endif

// ### hdl/vap_pkg.sv
// Types shared by the attribute stage modules.
package vap_pkg;

    typedef enum logic [1:0] {
        VAP_IF_VGA = 2'h0,
        VAP_IF_SPLIT = 2'h1,
        VAP_IF_EITHER = 2'h2
    } vap_if_mode_t;

    typedef enum logic [1:0] {
        VAP_ASM_HIGH = 2'b01,
        VAP_ASM_LOW = 2'b10
    } vap_asm_t;

    typedef struct packed {
        logic sel;
        logic [5:0] index;
        logic [15:0][5:0] colour;
        logic [7:0] mode;
        logic [7:0] border;
        logic [5:0] plane;
        logic [3:0] pan;
        logic [3:0] pad;
    } vap_regs_st_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic ack;
        logic rd_b;
        logic wr_b;
        logic [7:0] mask;
        logic [7:0] pal_idx;
        logic [7:0] pal_save;
        logic [1:0] pal_state;
        logic vsync;
        logic [7:0] blink_cnt;
        logic blink_on;
        logic [3:0] prev_pix;
        vap_asm_t asm_ph;
        logic [3:0] asm_hi;
        logic [7:0] video;
        logic vvalid;
        logic [7:0] pal_addr;
        logic [1:0] status;
        logic [3:0] pan;
    } vap_core_st_t;

endpackage

// ### hdl/vap_attr_if.sv
// Link between the stage and its attribute register file.
interface vap_attr_if;
    vap_pkg::vap_if_mode_t if_mode;
    logic wr_p0;
    logic wr_p1;
    logic clr_sel;
    logic [7:0] wdata;
    logic sel;
    logic [5:0] index;
    logic [7:0] data_rd;
    logic [15:0][5:0] colour;
    logic [7:0] mode;
    logic [7:0] border;
    logic [5:0] plane;
    logic [3:0] pan;
    logic [3:0] pad;

    modport ctrl (
        output if_mode, wr_p0, wr_p1, clr_sel, wdata,
        input sel, index, data_rd, colour, mode, border, plane, pan, pad
    );
    modport regs (
        input if_mode, wr_p0, wr_p1, clr_sel, wdata,
        output sel, index, data_rd, colour, mode, border, plane, pan, pad
    );
endinterface

// ### hdl/vap_attr_regs.sv
// Attribute index, selector flip-flop and attribute data registers.
`include "vap_params.svh"
module vap_attr_regs (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Access from the stage.
    vap_attr_if.regs bus
);
    vap_pkg::vap_regs_st_t st_q;
    vap_pkg::vap_regs_st_t st_d;
    logic [4:0] idx;
    logic idx_wr;
    logic data_wr;

    always_comb begin
        st_d = st_q;
        idx = st_q.index[4:0];
        idx_wr = 1'b0;
        data_wr = 1'b0;
        if (bus.clr_sel) begin
            st_d.sel = 1'b0; // [R1]
        end else if (bus.wr_p0 && bus.if_mode == vap_pkg::VAP_IF_SPLIT) begin
            idx_wr = 1'b1; // [R4]
        end else if (bus.wr_p0 ||
                     (bus.wr_p1 && bus.if_mode == vap_pkg::VAP_IF_EITHER)) begin
            idx_wr = !st_q.sel; // [R2] [R4]
            data_wr = st_q.sel;
            st_d.sel = !st_q.sel;
        end else if (bus.wr_p1) begin
            data_wr = 1'b1; // [R4]
        end
        if (idx_wr) begin
            st_d.index = bus.wdata[5:0];
        end
        if (data_wr) begin
            if (idx < `VAP_IDX_COLOUR_TOP) begin
                // Colour entries are locked while video is enabled.
                if (!st_q.index[`VAP_IDX_VIDEO_BIT]) begin
                    st_d.colour[idx[3:0]] = bus.wdata[5:0]; // [R5] [R6] [R7]
                end
            end else if (idx == `VAP_IDX_MODE) begin
                st_d.mode = bus.wdata & `VAP_MODE_WMASK;
            end else if (idx == `VAP_IDX_BORDER) begin
                st_d.border = bus.wdata;
            end else if (idx == `VAP_IDX_PLANE) begin
                st_d.plane = bus.wdata[5:0];
            end else if (idx == `VAP_IDX_PAN) begin
                st_d.pan = bus.wdata[3:0];
            end else if (idx == `VAP_IDX_PAD) begin
                st_d.pad = bus.wdata[3:0];
            end
        end
    end

    always_comb begin
        bus.data_rd = 8'h00;
        if (idx < `VAP_IDX_COLOUR_TOP) begin
            if (!st_q.index[`VAP_IDX_VIDEO_BIT]) begin
                bus.data_rd = {2'h0, st_q.colour[idx[3:0]]}; // [R7]
            end
        end else if (idx == `VAP_IDX_MODE) begin
            bus.data_rd = st_q.mode;
        end else if (idx == `VAP_IDX_BORDER) begin
            bus.data_rd = st_q.border;
        end else if (idx == `VAP_IDX_PLANE) begin
            bus.data_rd = {2'h0, st_q.plane};
        end else if (idx == `VAP_IDX_PAN) begin
            bus.data_rd = {4'h0, st_q.pan};
        end else if (idx == `VAP_IDX_PAD) begin
            bus.data_rd = {4'h0, st_q.pad};
        end
    end

    assign bus.sel = st_q.sel;
    assign bus.index = st_q.index;
    assign bus.colour = st_q.colour;
    assign bus.mode = st_q.mode;
    assign bus.border = st_q.border;
    assign bus.plane = st_q.plane;
    assign bus.pan = st_q.pan;
    assign bus.pad = st_q.pad;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_q <= '0; // [R24]
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ### hdl/vap_attr_stage.sv
// Attribute controller pixel stage with host ports and palette mask.
// Notes on behaviour
// R1 - Reading the input status port clears the attribute selector flip-flop.
// R2 - Each attribute port write toggles selector; clear loads index, set data.
// R3 - Reads ignore selector: index at first port, data at second.
// R4 - Extended modes: split index/data ports, or both usable at either.
// R5 - Index bits 4..0 pick the attribute register reached at data port.
// R6 - Index bit 5 clear opens colour table; set enables video, locks it. Code only locks; video path ignores bit 5.
// R7 - Sixteen colour entries hold six bits, upper two read zero.
// R8 - Mode bit 0 picks text or graphics, bit 1 colour or mono.
// R9 - Ninth dot repeats eighth for line-graphics codes if enabled, else background.
// R10 - Blink counter steps on vsync; bit 3 picks blink or background intensity.
// R11 - Mode bit 5 set limits panning to the top screen region.
// R12 - Mode bit 6 packs two nibbles into one byte at half rate.
// R13 - Mode bit 7 takes video bits 5..4 from pad bits 1..0.
// R14 - Border colour shown between display end and blank, blank and display.
// R15 - Cleared plane enable bits force pixel bits to zero before lookup.
// R16 - Plane register bits 5..4 choose two video bits for status.
// R17 - Panning shift: nine-dot uses value plus one, eight means zero.
// R18 - Host keeps panning bit 0 low in 256 mode; shift is half value.
// R19 - Pad bits 3..2 drive video 7..6 except in 256 mode.
// R20 - Pixel mask is ANDed with video before addressing the palette.
// R21 - Palette disabled: mask port accesses pulse external strobes, mask ignored.
// R22 - State reads 00 after write-mode index, 11 after read-mode; no strobe.
// R23 - Read-mode index write auto-increments; write-mode index write does not.
// R24 - Reset clears the selector so the first attribute write is an index.
`include "vap_params.svh"
module vap_attr_stage #(
    parameter logic [7:0] BLINK_VSYNCS = `VAP_BLINK_VSYNCS
) (
    // Clock and reset.
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    // Host I/O cycles.
    input wire logic [9:0] I_IO_ADDR,
    input wire logic I_IO_RD,
    input wire logic I_IO_WR,
    input wire logic [7:0] I_IO_WDATA,
    output logic [7:0] O_IO_RDATA,
    output logic O_IO_ACK,
    // Configuration.
    input wire logic [1:0] I_IF_MODE,
    input wire logic I_INT_PAL_EN,
    // Display timing.
    input wire logic I_VSYNC,
    input wire logic I_DISP_EN,
    input wire logic I_BLANK,
    input wire logic I_LOWER_SCREEN,
    input wire logic I_DOT9_MODE,
    // Pixel input.
    input wire logic I_PIX_VALID,
    input wire logic [3:0] I_PLANE_PIX,
    input wire logic I_DOT9,
    input wire logic [7:0] I_CHAR_CODE,
    input wire logic [3:0] I_BG_PIX,
    input wire logic I_BLINK_ATTR,
    // Video and palette outputs.
    output logic [3:0] O_PAN_SHIFT,
    output logic O_VIDEO_VALID,
    output logic [7:0] O_VIDEO,
    output logic [7:0] O_PAL_ADDR,
    output logic [7:0] O_PAL_INDEX,
    output logic [7:0] O_PAL_SAVE,
    output logic [1:0] O_STATUS_PIX,
    output logic O_EXT_PAL_RD_B,
    output logic O_EXT_PAL_WR_B
);
    vap_attr_if attr ();
    vap_pkg::vap_core_st_t st_q;
    vap_pkg::vap_core_st_t st_d;
    vap_pkg::vap_if_mode_t if_mode;
    logic stat_hit;
    logic [7:0] mode;
    logic gfx;
    logic [3:0] pix;
    logic [3:0] bg;
    logic [5:0] col;
    logic [7:0] vid;
    logic vid_ok;
    logic [7:0] addr_rd;

    vap_attr_regs u_regs (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .bus(attr)
    );

    // Any code outside the defined set is treated as plain VGA access.
    always_comb begin
        if (I_IF_MODE == 2'h1) begin
            if_mode = vap_pkg::VAP_IF_SPLIT;
        end else if (I_IF_MODE == 2'h2) begin
            if_mode = vap_pkg::VAP_IF_EITHER;
        end else begin
            if_mode = vap_pkg::VAP_IF_VGA;
        end
    end

    function automatic logic in_lg_range(input logic [7:0] code);
        in_lg_range = (code >= `VAP_LG_CODE_LO) && (code <= `VAP_LG_CODE_HI);
    endfunction

    assign stat_hit = (I_IO_ADDR == `VAP_PORT_STAT_MONO) ||
                      (I_IO_ADDR == `VAP_PORT_STAT_COLR);
    assign attr.if_mode = if_mode;
    assign attr.clr_sel = I_IO_RD && stat_hit; // [R1]
    assign attr.wr_p0 = I_IO_WR && (I_IO_ADDR == `VAP_PORT_ATTR);
    assign attr.wr_p1 = I_IO_WR && (I_IO_ADDR == `VAP_PORT_ATTR_DATA);
    assign attr.wdata = I_IO_WDATA;
    assign mode = attr.mode;
    assign gfx = mode[`VAP_MODE_GFX]; // [R8]

    // Attribute read value; only the either-port mode follows the selector.
    always_comb begin
        if (if_mode == vap_pkg::VAP_IF_EITHER && attr.sel) begin
            addr_rd = attr.data_rd; // [R4]
        end else if (if_mode == vap_pkg::VAP_IF_EITHER) begin
            addr_rd = {2'h0, attr.index};
        end else if (I_IO_ADDR == `VAP_PORT_ATTR) begin
            addr_rd = {2'h0, attr.index}; // [R3]
        end else begin
            addr_rd = attr.data_rd; // [R3]
        end
    end

    // Pixel path up to the 8-bit video value.
    always_comb begin
        // Intensity of the background is dropped when blink owns bit 3.
        bg = I_BG_PIX;
        if (mode[`VAP_MODE_BLINK] || mode[`VAP_MODE_MONO]) begin
            bg[3] = 1'b0; // [R10] [R8]
        end
        pix = I_PLANE_PIX & attr.plane[3:0]; // [R15]
        if (I_DOT9) begin
            if (mode[`VAP_MODE_LGFX] && !gfx && in_lg_range(I_CHAR_CODE)) begin
                pix = st_q.prev_pix; // [R9]
            end else begin
                pix = bg; // [R9]
            end
        end
        if (mode[`VAP_MODE_BLINK] && I_BLINK_ATTR && !st_q.blink_on) begin
            pix = gfx ? (pix ^ 4'h8) : bg; // [R10]
        end
        col = attr.colour[pix]; // [R7]
        vid[3:0] = col[3:0];
        vid[5:4] = mode[`VAP_MODE_PADSEL] ? attr.pad[1:0] : col[5:4]; // [R13]
        vid[7:6] = attr.pad[3:2]; // [R19]
        vid_ok = I_PIX_VALID;
        if (mode[`VAP_MODE_ASM256]) begin
            // First nibble of a pair is held as the high half.
            vid = {st_q.asm_hi, pix}; // [R12] [R19]
            vid_ok = I_PIX_VALID && (st_q.asm_ph == vap_pkg::VAP_ASM_LOW);
        end
        if (!I_DISP_EN && !I_BLANK) begin
            vid = attr.border; // [R14]
            vid_ok = 1'b1;
        end else if (!I_DISP_EN) begin
            vid = 8'h00;
            vid_ok = 1'b0;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.ack = I_IO_RD;
        st_d.rd_b = 1'b1;
        st_d.wr_b = 1'b1;
        // Host reads.
        if (I_IO_RD) begin
            if (I_IO_ADDR == `VAP_PORT_ATTR ||
                I_IO_ADDR == `VAP_PORT_ATTR_DATA) begin
                st_d.rdata = addr_rd;
            end else if (I_IO_ADDR == `VAP_PORT_MASK) begin
                st_d.rdata = st_q.mask;
                st_d.rd_b = I_INT_PAL_EN; // [R21]
            end else if (I_IO_ADDR == `VAP_PORT_PAL_RIDX) begin
                st_d.rdata = {6'h00, st_q.pal_state}; // [R22]
            end else if (I_IO_ADDR == `VAP_PORT_PAL_WIDX) begin
                st_d.rdata = st_q.pal_idx;
                st_d.rd_b = I_INT_PAL_EN;
            end else if (stat_hit) begin
                st_d.rdata = {2'h0, st_q.status, 4'h0}; // [R16]
            end else begin
                st_d.rdata = 8'h00;
            end
        end
        // Host writes to the palette side.
        if (I_IO_WR) begin
            if (I_IO_ADDR == `VAP_PORT_MASK) begin
                st_d.mask = I_IO_WDATA;
                st_d.wr_b = I_INT_PAL_EN; // [R21]
            end else if (I_IO_ADDR == `VAP_PORT_PAL_RIDX) begin
                st_d.pal_save = I_IO_WDATA;
                st_d.pal_idx = I_IO_WDATA + 8'h01; // [R23]
                st_d.pal_state = `VAP_STATE_RMODE; // [R22]
                st_d.wr_b = I_INT_PAL_EN;
            end else if (I_IO_ADDR == `VAP_PORT_PAL_WIDX) begin
                st_d.pal_save = I_IO_WDATA;
                st_d.pal_idx = I_IO_WDATA; // [R23]
                st_d.pal_state = `VAP_STATE_WMODE; // [R22]
                st_d.wr_b = I_INT_PAL_EN;
            end
        end
        // Blink counter advances on each rising edge of vertical sync; the phase flips every BLINK_VSYNCS edges.
        st_d.vsync = I_VSYNC;
        if (I_VSYNC && !st_q.vsync) begin
            if (st_q.blink_cnt >= BLINK_VSYNCS - 8'h01) begin
                st_d.blink_cnt = 8'h00; // [R10]
                st_d.blink_on = !st_q.blink_on;
            end else begin
                st_d.blink_cnt = st_q.blink_cnt + 8'h01; // [R10]
            end
        end
        // Pair assembly and ninth-dot history.
        if (I_PIX_VALID && I_DISP_EN) begin
            st_d.prev_pix = pix;
            if (mode[`VAP_MODE_ASM256]) begin
                case (st_q.asm_ph)
                    vap_pkg::VAP_ASM_HIGH: begin
                        st_d.asm_hi = pix; // [R12]
                        st_d.asm_ph = vap_pkg::VAP_ASM_LOW;
                    end
                    default: begin
                        st_d.asm_ph = vap_pkg::VAP_ASM_HIGH;
                    end
                endcase
            end
        end
        if (!I_DISP_EN || !mode[`VAP_MODE_ASM256]) begin
            st_d.asm_ph = vap_pkg::VAP_ASM_HIGH;
        end
        st_d.video = vid;
        st_d.vvalid = vid_ok;
        st_d.pal_addr = I_INT_PAL_EN ? (vid & st_q.mask) : vid; // [R20] [R21]
        case (attr.plane[5:4])
            2'h0: st_d.status = {vid[2], vid[0]}; // [R16]
            2'h1: st_d.status = {vid[5], vid[4]};
            2'h2: st_d.status = {vid[3], vid[1]};
            default: st_d.status = {vid[7], vid[6]};
        endcase
        // Panning amount handed to the shifter.
        if (mode[`VAP_MODE_PANSPLIT] && I_LOWER_SCREEN) begin
            st_d.pan = 4'h0; // [R11]
        end else if (mode[`VAP_MODE_ASM256]) begin
            st_d.pan = {1'b0, attr.pan[3:1]}; // [R18]
        end else if (I_DOT9_MODE && !gfx) begin
            if (attr.pan < `VAP_PAN_NINE_ZERO) begin
                st_d.pan = attr.pan + 4'h1; // [R17]
            end else begin
                st_d.pan = 4'h0; // [R17]
            end
        end else begin
            st_d.pan = attr.pan; // [R17]
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            st_q <= '0;
            st_q.rd_b <= 1'b1;
            st_q.wr_b <= 1'b1;
            st_q.mask <= `VAP_MASK_RST;
            st_q.asm_ph <= vap_pkg::VAP_ASM_HIGH;
        end else begin
            st_q <= st_d;
        end
    end

    assign O_IO_RDATA = st_q.rdata;
    assign O_IO_ACK = st_q.ack;
    assign O_PAN_SHIFT = st_q.pan;
    assign O_VIDEO_VALID = st_q.vvalid;
    assign O_VIDEO = st_q.video;
    assign O_PAL_ADDR = st_q.pal_addr;
    assign O_PAL_INDEX = st_q.pal_idx;
    assign O_PAL_SAVE = st_q.pal_save;
    assign O_STATUS_PIX = st_q.status;
    assign O_EXT_PAL_RD_B = st_q.rd_b;
    assign O_EXT_PAL_WR_B = st_q.wr_b;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    AST_SEL_CLEAR: assert property ( // [R1]
        I_IO_RD && stat_hit |=> !attr.sel
    ) else $error("selector not cleared by status read");
    AST_SEL_TOGGLE: assert property ( // [R2]
        attr.wr_p0 && if_mode == vap_pkg::VAP_IF_VGA
        |=> attr.sel != $past(attr.sel)
    ) else $error("selector did not toggle");
    AST_INDEX_READ: assert property ( // [R3]
        I_IO_RD && I_IO_ADDR == `VAP_PORT_ATTR && if_mode != vap_pkg::VAP_IF_EITHER
        |=> O_IO_RDATA == {2'h0, $past(attr.index)} && O_IO_ACK
    ) else $error("index read back wrong");
    AST_SPLIT_INDEX: assert property ( // [R4]
        attr.wr_p0 && if_mode == vap_pkg::VAP_IF_SPLIT
        |=> attr.index == $past(I_IO_WDATA[5:0]) && $stable(attr.sel)
    ) else $error("split mode index write wrong");
    AST_COLOUR_LOCK: assert property ( // [R6]
        attr.index[`VAP_IDX_VIDEO_BIT] && attr.index[4:0] < `VAP_IDX_COLOUR_TOP
        |=> $stable(attr.colour)
    ) else $error("colour table changed with video on");
    AST_BORDER: assert property ( // [R14]
        !I_DISP_EN && !I_BLANK
        |=> O_VIDEO == $past(attr.border) && O_VIDEO_VALID
    ) else $error("border colour not shown");
    AST_MASK_AND: assert property ( // [R20]
        I_INT_PAL_EN |=> O_PAL_ADDR == (O_VIDEO & $past(st_q.mask))
    ) else $error("palette address not masked");
    AST_RMODE_INC: assert property ( // [R23]
        I_IO_WR && I_IO_ADDR == `VAP_PORT_PAL_RIDX
        |=> O_PAL_INDEX == $past(I_IO_WDATA) + 8'h01
    ) else $error("read mode index not incremented");
    AST_STATE_READ: assert property ( // [R22]
        I_IO_WR && I_IO_ADDR == `VAP_PORT_PAL_RIDX ##1 !I_IO_WR ##1
        I_IO_RD && I_IO_ADDR == `VAP_PORT_PAL_RIDX
        |=> O_IO_RDATA == {6'h00, `VAP_STATE_RMODE} && O_EXT_PAL_RD_B
    ) else $error("palette state wrong or strobe asserted");
    AST_EXT_WR: assert property ( // [R21]
        I_IO_WR && I_IO_ADDR == `VAP_PORT_MASK && !I_INT_PAL_EN
        |=> !O_EXT_PAL_WR_B ##1 O_EXT_PAL_WR_B || $past(I_IO_WR)
    ) else $error("external write strobe wrong");
    AST_PAN_NINE: assert property ( // [R17]
        I_DOT9_MODE && !gfx && attr.pan == `VAP_PAN_NINE_ZERO &&
        !mode[`VAP_MODE_ASM256] && !mode[`VAP_MODE_PANSPLIT]
        |=> O_PAN_SHIFT == 4'h0
    ) else $error("nine-dot pan of eight not zero");

    COV_ASM_PAIR: cover property (
        mode[`VAP_MODE_ASM256] && I_DISP_EN && I_PIX_VALID ##1
        I_DISP_EN && I_PIX_VALID ##1 O_VIDEO_VALID
    );
    COV_BORDER: cover property (I_DISP_EN ##1 !I_DISP_EN && !I_BLANK);
    COV_ATTR_SEQ: cover property (
        I_IO_RD && stat_hit ##[1:4] attr.wr_p0 ##[1:4] attr.wr_p0
    );
    COV_EXT_PAL: cover property (!O_EXT_PAL_RD_B);
endmodule

// ### verif/vap_host_model.sv
// Host CPU model that issues single-cycle I/O reads and writes.
module vap_host_model (
    // Clock.
    input wire logic i_clk,
    // I/O cycle.
    output logic [9:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_addr = 10'h000;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end

    // Released lines show the inverse of their last value.
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic io_rd(input logic [9:0] a, output logic [7:0] d,
                         output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        for (int n = 0; n < 4 && ok !== 1'b1; n++) begin
            #1;
            if (i_ack === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end else begin
                @(posedge i_clk);
            end
        end
    endtask
endmodule

// ### verif/test_vap_attr_stage.sv
// Self-checking bench for the attribute pixel stage.
module test_vap_attr_stage;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] if_mode = 2'h0;
    logic pal_en = 1'b1;
    logic disp_en = 1'b0;
    logic pix_valid = 1'b0;
    logic [3:0] plane_pix = 4'h0;
    logic blank = 1'b0;
    logic lower = 1'b0;
    logic dot9_mode = 1'b0;
    logic dot9 = 1'b0;
    logic [3:0] pan_shift;
    logic vvalid;
    logic [9:0] io_addr;
    logic io_rd;
    logic io_wr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_ack;
    logic [7:0] video;
    logic [7:0] pal_addr;
    logic [7:0] pal_index;
    logic [7:0] pal_save;
    logic [1:0] status_pix;
    logic rd_b;
    logic wr_b;
    int miscompares = 0;
    int tests_run = 0;

    always #10 clk = ~clk;

    vap_attr_stage #(.BLINK_VSYNCS(8'h02)) dut_u (
        .I_SYS_CLK(clk), .I_RST_B(rst_b),
        .I_IO_ADDR(io_addr), .I_IO_RD(io_rd), .I_IO_WR(io_wr),
        .I_IO_WDATA(io_wdata), .O_IO_RDATA(io_rdata), .O_IO_ACK(io_ack),
        .I_IF_MODE(if_mode), .I_INT_PAL_EN(pal_en),
        .I_VSYNC(1'b0), .I_DISP_EN(disp_en), .I_BLANK(blank),
        .I_LOWER_SCREEN(lower), .I_DOT9_MODE(dot9_mode),
        .I_PIX_VALID(pix_valid), .I_PLANE_PIX(plane_pix), .I_DOT9(dot9),
        .I_CHAR_CODE(8'h00), .I_BG_PIX(4'h0), .I_BLINK_ATTR(1'b0),
        .O_PAN_SHIFT(pan_shift), .O_VIDEO_VALID(vvalid), .O_VIDEO(video),
        .O_PAL_ADDR(pal_addr), .O_PAL_INDEX(pal_index),
        .O_PAL_SAVE(pal_save), .O_STATUS_PIX(status_pix),
        .O_EXT_PAL_RD_B(rd_b), .O_EXT_PAL_WR_B(wr_b)
    );

    vap_host_model host_u (
        .i_clk(clk), .o_addr(io_addr), .o_rd(io_rd), .o_wr(io_wr),
        .o_wdata(io_wdata), .i_rdata(io_rdata), .i_ack(io_ack)
    );

    task automatic results();
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A read that never answers ends the run.
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp,
                          input string what);
        logic [7:0] d;
        logic ok;
        host_u.io_rd(a, d, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            results();
        end else begin
            chk(what, d, exp);
        end
    endtask

    task automatic wr_pair(input logic [7:0] idx, input logic [7:0] val);
        host_u.io_wr(10'h3C0, idx);
        host_u.io_wr(10'h3C0, val);
    endtask

    task automatic sc_attr();
        rd_chk(10'h3C0, 8'h00, "index after reset");
        wr_pair(8'h10, 8'h81);
        rd_chk(10'h3C1, 8'h81, "mode");
        rd_chk(10'h3C0, 8'h10, "index");
        host_u.io_wr(10'h3C0, 8'h14);
        rd_chk(10'h3DA, 8'h00, "input status");
        host_u.io_wr(10'h3C0, 8'h02);
        rd_chk(10'h3C0, 8'h02, "index after status read");
        host_u.io_wr(10'h3C0, 8'hFF);
        rd_chk(10'h3C1, 8'h3F, "colour entry");
        wr_pair(8'h22, 8'h00);
        rd_chk(10'h3C1, 8'h00, "locked colour entry");
        wr_pair(8'h34, 8'h0D);
        wr_pair(8'h31, 8'hA5);
        wr_pair(8'h32, 8'h0E);
    endtask

    task automatic sc_pixel();
        @(posedge clk);
        disp_en <= 1'b1;
        pix_valid <= 1'b1;
        plane_pix <= 4'h3;
        @(posedge clk);
        #1;
        chk("video", video, 8'hDF);
        chk("status pick", {6'h00, status_pix}, 8'h03);
        chk("palette address", pal_addr, 8'hDF);
        host_u.io_wr(10'h3C6, 8'h0F);
        @(posedge clk);
        #1;
        chk("masked address", pal_addr, 8'h0F);
        @(posedge clk);
        pal_en <= 1'b0;
        @(posedge clk);
        #1;
        chk("unmasked address", pal_addr, 8'hDF);
        @(posedge clk);
        disp_en <= 1'b0;
        @(posedge clk);
        #1;
        chk("border", video, 8'hA5);
        chk("border valid", {7'h00, vvalid}, 8'h01);
    endtask

    task automatic sc_pan();
        wr_pair(8'h33, 8'h07);
        wr_pair(8'h30, 8'h20);
        dot9_mode <= 1'b1;
        @(posedge clk);
        #1;
        chk("pan 9-dot", {4'h0, pan_shift}, 8'h08);
        @(posedge clk);
        lower <= 1'b1;
        @(posedge clk);
        #1;
        chk("pan lower", {4'h0, pan_shift}, 8'h00);
        wr_pair(8'h33, 8'h08);
        wr_pair(8'h30, 8'h00);
        disp_en <= 1'b1;
        dot9 <= 1'b1;
        @(posedge clk);
        #1;
        chk("pan eight", {4'h0, pan_shift}, 8'h00);
        chk("ninth dot", video, 8'hC0);
        @(posedge clk);
        disp_en <= 1'b0;
        dot9 <= 1'b0;
        blank <= 1'b1;
        @(posedge clk);
        #1;
        chk("blank video", video, 8'h00);
        chk("blank valid", {7'h00, vvalid}, 8'h00);
        @(posedge clk);
        blank <= 1'b0;
        wr_pair(8'h33, 8'h06);
        wr_pair(8'h30, 8'h40);
        @(posedge clk);
        #1;
        chk("pan 256", {4'h0, pan_shift}, 8'h03);
    endtask

    task automatic sc_palette();
        logic [7:0] d;
        logic ok;
        host_u.io_wr(10'h3C6, 8'h55);
        #1;
        chk("write strobe", {7'h00, wr_b}, 8'h00);
        host_u.io_rd(10'h3C6, d, ok);
        chk("read strobe", {7'h00, rd_b & ok}, 8'h00);
        host_u.io_wr(10'h3C7, 8'h10);
        rd_chk(10'h3C7, 8'h03, "state read mode");
        chk("no read strobe", {7'h00, rd_b}, 8'h01);
        chk("read index", pal_index, 8'h11);
        chk("read save", pal_save, 8'h10);
        host_u.io_wr(10'h3C8, 8'h20);
        rd_chk(10'h3C7, 8'h00, "state write mode");
        chk("write index", pal_index, 8'h20);
    endtask

    task automatic sc_split();
        @(posedge clk);
        if_mode <= 2'h1;
        host_u.io_wr(10'h3C0, 8'h33);
        host_u.io_wr(10'h3C0, 8'h13);
        host_u.io_wr(10'h3C1, 8'h06);
        rd_chk(10'h3C0, 8'h13, "split index");
        rd_chk(10'h3C1, 8'h06, "split data");
        @(posedge clk);
        if_mode <= 2'h2;
        rd_chk(10'h3DA, 8'h30, "input status");
        host_u.io_wr(10'h3C1, 8'h32);
        rd_chk(10'h3C1, 8'h0E, "either-port data");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        sc_attr();
        sc_pixel();
        sc_palette();
        sc_pan();
        sc_split();
        results();
    end
endmodule
